// >>> hw/ddc_core.sv
// Contract
// (RQ1) sixteen banks for x4/x8, eight for x16
// (RQ2) eight-n prefetch, two words per clock
// (RQ3) one access moves 8n word over four clocks
// (RQ4) host uses deselect, not no-operation, when idle
// (RQ5) host toggles clock enable every 8192 intervals
// (RQ6) or toggles chip select when enable stays high
// (RQ7) host issues only defined commands
// (RQ8) termination state terminates or floats, never drives
// (RQ9) chip select high masks the command
`timescale 1ns/1ps
`include "ddc_regs.svh"

module ddc_core #(
	parameter logic [`DDC_TOGGLE_CNT_W-1:0] TOGGLE_LIMIT =
		`DDC_TOGGLE_CNT_W'(`DDC_TOGGLE_LIMIT_CYC)
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic org_x16_strap,
	input wire logic cke,
	input wire ddc_pkg::ddc_cmd_t cmd,
	input wire logic on_die_termination,
	input wire ddc_pkg::ddc_beat_t dq_i,
	input wire logic dq_rd_ready,
	output ddc_pkg::ddc_beat_t dq_o,
	output logic dq_oe,
	output logic dq_term,
	output logic cmd_busy,
	output logic usable
);
	import ddc_pkg::*;

	ddc_state_t state;
	ddc_state_t next_state;
	logic org_x16;
	logic strap_taken;
	logic term_en;
	logic [1:0] wr_idx;
	logic [`DDC_WORD_W-1:0] wr_word;
	logic [`DDC_MEM_AW-1:0] wr_addr;
	logic rd_pend;
	logic [`DDC_WORD_W-1:0] mem_rdata;
	logic [`DDC_WORD_W-1:0] buf0;
	logic [`DDC_WORD_W-1:0] buf1;
	logic [1:0] buf_count;
	logic [1:0] next_count;
	logic ser_active;
	logic [1:0] ser_idx;
	logic [`DDC_WORD_W-1:0] ser_word;
	logic cke_q;
	logic cs_n_q;
	logic [`DDC_TOGGLE_CNT_W-1:0] toggle_cnt;

	// command decode; unknown codes and the no-operation code fall through
	wire cmd_live = !cmd.cs_n && cke && state == DDC_ST_IDLE; // see RQ9
	wire is_col = !cmd.act_n && 1'b0 || (cmd.act_n && cmd.ras_n &&
		!cmd.cas_n);
	wire is_mrs = cmd.act_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
	wire rd_room = buf_count == 2'h0 || (buf_count == 2'h1 && !rd_pend);
	wire rd_take = cmd_live && is_col && cmd.we_n && rd_room; // see RQ7
	wire wr_take = cmd_live && is_col && !cmd.we_n;
	wire mrs_take = cmd_live && is_mrs;
	// x16 drops the upper bank-group bit: eight banks, else sixteen
	wire [`DDC_BANK_W-1:0] bank_idx =
		org_x16 ? {1'b0, cmd.bg[0], cmd.ba} : {cmd.bg, cmd.ba}; // see RQ1
	wire [`DDC_MEM_AW-1:0] cmd_addr = {bank_idx, cmd.col};
	wire mem_we = state == DDC_ST_WRITE && wr_idx == 2'h3; // see RQ3
	wire [`DDC_WORD_W-1:0] mem_wdata = {dq_i, wr_word[47:0]};
	wire pop = buf_count != 2'h0 &&
		(!ser_active || (ser_idx == 2'h3 && dq_rd_ready));
	wire push = rd_pend;
	wire ddc_beat_t ser_beat = ser_word[ser_idx*`DDC_BEAT_W +: `DDC_BEAT_W];
	// periodic toggle watch: clock enable, or chip select with enable high
	wire toggled = cke != cke_q ||
		(cke && cke_q && cmd.cs_n != cs_n_q); // see RQ5 see RQ6

	ddc_mem u_mem (
		.mclk(mclk),
		.we(mem_we),
		.waddr(wr_addr),
		.wdata(mem_wdata),
		.re(rd_take),
		.raddr(cmd_addr),
		.rdata(mem_rdata)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			DDC_ST_IDLE: if (wr_take) begin
				next_state = DDC_ST_WRITE;
			end
			DDC_ST_WRITE: if (wr_idx == 2'h3) begin
				next_state = DDC_ST_IDLE;
			end
		endcase
	end

	always_comb begin
		next_count = buf_count;
		if (push && !pop) begin
			next_count = buf_count + 2'h1;
		end else if (pop && !push) begin
			next_count = buf_count - 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			strap_taken <= 1'b0;
			org_x16 <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			org_x16 <= org_x16_strap;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state <= DDC_ST_IDLE;
			wr_idx <= 2'h0;
			wr_addr <= '0;
			term_en <= `DDC_TERM_EN_RST;
			rd_pend <= 1'b0;
		end else begin
			state <= next_state;
			wr_idx <= state == DDC_ST_WRITE ? wr_idx + 2'h1 : 2'h0;
			if (wr_take) begin
				wr_addr <= cmd_addr;
			end
			if (mrs_take) begin
				term_en <= cmd.spare[`DDC_MR_TERM_BIT];
			end
			rd_pend <= rd_take;
		end
	end

	// write beats land in the core word, first beat in the low bits
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_word <= '0;
		end else if (state == DDC_ST_WRITE) begin
			wr_word[wr_idx*`DDC_BEAT_W +: `DDC_BEAT_W] <= dq_i; // see RQ2
		end
	end

	// two-entry buffer between core fetch and pin serializer
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			buf0 <= '0;
			buf1 <= '0;
			buf_count <= 2'h0;
		end else begin
			buf_count <= next_count;
			if (push && (pop ? buf_count == 2'h1 : buf_count == 2'h0)) begin
				buf0 <= mem_rdata;
			end else if (pop) begin
				buf0 <= buf1;
			end
			if (push && (pop ? buf_count == 2'h2 : buf_count == 2'h1)) begin
				buf1 <= mem_rdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ser_active <= 1'b0;
			ser_idx <= 2'h0;
			ser_word <= '0;
		end else if (pop) begin
			ser_active <= 1'b1;
			ser_idx <= 2'h0;
			ser_word <= buf0;
		end else if (ser_active && dq_rd_ready) begin
			ser_active <= ser_idx != 2'h3; // see RQ3
			ser_idx <= ser_idx + 2'h1;
		end
	end

	// pins: a beat leaves once per accepted clock; idle pins never drive
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dq_o <= '0;
			dq_oe <= 1'b0;
			dq_term <= 1'b0;
			cmd_busy <= 1'b0;
		end else begin
			dq_o <= ser_beat; // see RQ2
			dq_oe <= ser_active && dq_rd_ready;
			dq_term <= on_die_termination && term_en && !ser_active; // see RQ8
			cmd_busy <= next_state == DDC_ST_WRITE || !(next_count == 2'h0 ||
				(next_count == 2'h1 && !rd_take));
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cke_q <= 1'b0;
			cs_n_q <= 1'b1;
			toggle_cnt <= '0;
			usable <= 1'b1;
		end else begin
			cke_q <= cke;
			cs_n_q <= cmd.cs_n;
			if (toggled) begin
				toggle_cnt <= '0;
			end else if (toggle_cnt != TOGGLE_LIMIT) begin
				toggle_cnt <= toggle_cnt + 1'b1;
			end
			usable <= toggled || toggle_cnt != TOGGLE_LIMIT; // see RQ5
		end
	end

	sequence s_write_beats;
		state == DDC_ST_WRITE && !mem_we [*3] ##1 mem_we;
	endsequence

	sequence s_four_accepts;
		pop ##1 dq_rd_ready [*4];
	endsequence

	chk_bank_count: assert property ( // see RQ1
		@(posedge mclk) disable iff (!rstn)
		org_x16 |-> !bank_idx[3])
		else $error("x16 part addressed a ninth bank");

	chk_cs_masks: assert property ( // see RQ9
		@(posedge mclk) disable iff (!rstn)
		state == DDC_ST_IDLE && cmd.cs_n |=> state == DDC_ST_IDLE && !rd_pend)
		else $error("command taken with chip select high");

	chk_write_four_clk: assert property ( // see RQ3
		@(posedge mclk) disable iff (!rstn)
		wr_take |=> s_write_beats ##1 state == DDC_ST_IDLE)
		else $error("write did not take four clocks");

	chk_read_fetch: assert property ( // see RQ3
		@(posedge mclk) disable iff (!rstn)
		rd_take |=> rd_pend ##1 buf_count != 2'h0 || ser_active)
		else $error("read word did not reach the buffer");

	chk_burst_beats: assert property ( // see RQ2
		@(posedge mclk) disable iff (!rstn)
		s_four_accepts |=> dq_oe && ser_idx == 2'h0)
		else $error("read word not sent in four clocks");

	chk_term_float: assert property ( // see RQ8
		@(posedge mclk) disable iff (!rstn)
		on_die_termination && term_en && !ser_active |=> dq_term && !dq_oe)
		else $error("termination state drove the pins");
endmodule : ddc_core

// >>> hw/ddc_mem.sv
`timescale 1ns/1ps
`include "ddc_regs.svh"

module ddc_mem (
	input wire logic mclk,
	input wire logic we,
	input wire logic [`DDC_MEM_AW-1:0] waddr,
	input wire logic [`DDC_WORD_W-1:0] wdata,
	input wire logic re,
	input wire logic [`DDC_MEM_AW-1:0] raddr,
	output logic [`DDC_WORD_W-1:0] rdata
);
	logic [`DDC_WORD_W-1:0] cells [0:`DDC_MEM_DEPTH-1];

	always_ff @(posedge mclk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
		if (re) begin
			rdata <= cells[raddr];
		end
	end
endmodule : ddc_mem

// >>> pkg/ddc_pkg.sv
`include "ddc_regs.svh"

package ddc_pkg;

	typedef struct packed {
		logic cs_n;
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bg;
		logic [1:0] ba;
		logic [`DDC_COL_W-1:0] col;
		logic [`DDC_COL_W-1:0] spare;
	} ddc_cmd_t;

	// two n-bit words per clock: lo is the first half, hi the second
	typedef struct packed {
		logic [`DDC_PIN_W-1:0] hi;
		logic [`DDC_PIN_W-1:0] lo;
	} ddc_beat_t;

	typedef enum logic [1:0] {
		DDC_ST_IDLE = 2'h1,
		DDC_ST_WRITE = 2'h2
	} ddc_state_t;

endpackage : ddc_pkg

// >>> pkg/ddc_regs.svh
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH

// pin and core widths (n = 8 data pins)
`define DDC_PIN_W 8
`define DDC_BEAT_W 16
`define DDC_WORD_W 64
`define DDC_BEATS 4
`define DDC_COL_W 2
`define DDC_BANK_W 4
`define DDC_MEM_AW 6
`define DDC_MEM_DEPTH 64

// timing
`define DDC_CLK_PERIOD_PS 25000
`define DDC_AVG_REFRESH_INTERVAL_PS 7800000
`define DDC_AVG_REFRESH_INTERVAL_CYC \
	(`DDC_AVG_REFRESH_INTERVAL_PS / `DDC_CLK_PERIOD_PS)
`define DDC_TOGGLE_INTERVALS 8192
`define DDC_TOGGLE_LIMIT_CYC \
	(`DDC_AVG_REFRESH_INTERVAL_CYC * `DDC_TOGGLE_INTERVALS)
`define DDC_TOGGLE_CNT_W 22

// mode register field: bit 0 of the address selects termination
`define DDC_MR_TERM_BIT 0
`define DDC_TERM_EN_RST 1'h1

`endif

// >>> testbench/ddc_host_model.sv
`timescale 1ns/1ps
module ddc_host_model (
	input wire logic mclk,
	output ddc_pkg::ddc_cmd_t cmd,
	output ddc_pkg::ddc_beat_t dq_i,
	output logic dq_rd_ready,
	input wire ddc_pkg::ddc_beat_t dq_o,
	input wire logic dq_oe
);
	import ddc_pkg::*;
	// idle cycles carry deselect only
	initial cmd = '1;
	initial dq_i = '0;
	initial dq_rd_ready = 1'b1;

	// op is {ras_n, cas_n, we_n}; a is {bank, col, spare}
	task automatic issue(input logic cs_n, input logic [2:0] op,
		input logic [7:0] a);
		@(posedge mclk);
		cmd <= {cs_n, 1'b1, op, a};
		@(posedge mclk);
		cmd.cs_n <= 1'b1;
	endtask : issue

	task automatic wr(input logic cs_n, input logic [5:0] a,
		input logic [63:0] d);
		@(posedge mclk);
		cmd <= {cs_n, 1'b1, 3'h4, a, 2'h0};
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			cmd.cs_n <= 1'b1;
			dq_i <= d[16*i +: 16];
		end
		@(posedge mclk);
		dq_i <= ~dq_i;
	endtask : wr

	// the host stalls at random while beats come back
	task automatic rd(input logic [5:0] a, output logic [63:0] d);
		int n;
		n = 0;
		d = 'x;
		issue(1'b0, 3'h5, {a, 2'h0});
		for (int i = 0; i < 40 && n < 4; i++) begin
			dq_rd_ready <= $urandom_range(3) != 0;
			@(posedge mclk);
			#1;
			if (dq_oe === 1'b1) begin
				d[16*n +: 16] = dq_o;
				n++;
			end
		end
		dq_rd_ready <= 1'b1;
	endtask : rd
endmodule : ddc_host_model

// >>> testbench/test_ddr4_core_organization_rules.sv
`timescale 1ns/1ps
module test_ddr4_core_organization_rules;
	import ddc_pkg::*;
	logic mclk = 0;
	logic rstn = 0;
	logic strap = 0;
	logic cke = 1;
	logic on_die_termination = 1;
	ddc_cmd_t cmd;
	ddc_beat_t dq_i;
	ddc_beat_t dq_o;
	logic dq_rd_ready, dq_oe, dq_term, cmd_busy, usable;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [63:0] mem [64];
	logic [63:0] d;
	logic [5:0] a;

	initial forever #12.5 mclk = ~mclk;

	ddc_host_model i_host (.mclk, .cmd, .dq_i, .dq_rd_ready, .dq_o, .dq_oe);
	ddc_core #(.TOGGLE_LIMIT(22'h32)) i_dut (.mclk, .rstn,
		.org_x16_strap(strap), .cke, .cmd, .on_die_termination, .dq_i, .dq_rd_ready,
		.dq_o, .dq_oe, .dq_term, .cmd_busy, .usable);

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("checked %0d, wrong %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic do_reset(input logic x16);
		@(posedge mclk);
		rstn <= 0;
		strap <= x16;
		repeat (20) @(posedge mclk);
		rstn <= 1;
		repeat (2) @(posedge mclk);
		#1;
	endtask : do_reset

	initial begin
		void'($urandom(11691));
		do_reset(0);
		check(64'({dq_oe, cmd_busy, usable, dq_term}), 64'h3);
		i_host.issue(1'b0, 3'h0, 8'h00);
		repeat (3) @(posedge mclk);
		check(64'(dq_term), 64'h0);
		i_host.issue(1'b0, 3'h0, 8'h01);
		repeat (3) @(posedge mclk);
		check(64'(dq_term), 64'h1);
		for (int i = 0; i < 64; i++) begin
			mem[i] = {$urandom, $urandom};
			i_host.wr(1'b0, 6'(i), mem[i]);
		end
		repeat (30) begin
			a = 6'($urandom);
			if ($urandom_range(1) == 1) begin
				mem[a] = {$urandom, $urandom};
				i_host.wr(1'b0, a, mem[a]);
			end else begin
				i_host.rd(a, d);
				check(d, mem[a]);
			end
		end
		fork
			i_host.wr(1'b0, 6'h07, mem[7]);
			begin
				repeat (2) @(posedge mclk);
				#1;
				check(64'(cmd_busy), 64'h1);
			end
		join
		i_host.wr(1'b1, 6'h05, 64'h0123_4567_89ab_cdef);
		i_host.rd(6'h05, d);
		check(d, mem[5]);
		@(posedge mclk);
		cke <= 0;
		i_host.wr(1'b0, 6'h06, 64'h0123_4567_89ab_cdef);
		cke <= 1;
		i_host.rd(6'h06, d);
		check(d, mem[6]);
		check(64'(usable), 64'h1);
		repeat (60) @(posedge mclk);
		check(64'(usable), 64'h0);
		do_reset(1);
		i_host.wr(1'b0, 6'h21, 64'h1111_2222_3333_4444);
		i_host.wr(1'b0, 6'h01, 64'h5555_6666_7777_8888);
		i_host.wr(1'b0, 6'h11, 64'h9999_aaaa_bbbb_cccc);
		i_host.rd(6'h21, d);
		check(d, 64'h5555_6666_7777_8888);
		i_host.rd(6'h01, d);
		check(d, 64'h5555_6666_7777_8888);
		finish_test();
	end
endmodule : test_ddr4_core_organization_rules
